// *** core/spp_cfg.svh ***
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH
// supply levels in millivolts (typical) for reference
`define SPP_LOW_MV          16'h1388
`define SPP_MID_MV          16'h3A98
`define SPP_HIGH_MV         16'h6978
// least pulse and gap time, ns, and clock period, ns
`define SPP_T_MIN_NS        32'h0000_9C40
`define SPP_CLK_NS          32'h0000_0064
// qualification time; shorter than the 40 us least so legal pulses pass
`define SPP_T_QUAL_NS       32'h0000_2710
`define SPP_QUAL_CYC        ((`SPP_T_QUAL_NS + `SPP_CLK_NS - 1) / `SPP_CLK_NS)
// least blow time in cycles, rounded up
`define SPP_BLOW_CYC        ((`SPP_T_MIN_NS + `SPP_CLK_NS - 1) / `SPP_CLK_NS)
// mode keys
`define SPP_KEY_BLOW        4'h1
`define SPP_KEY_TRY         4'h2
// parameter keys
`define SPP_KEY_SENS        4'h1
`define SPP_KEY_DQ_FINE     4'h2
`define SPP_KEY_FPWM_CRS    4'h3
`define SPP_KEY_NULL        4'h4
`define SPP_KEY_TEST        4'h5
`endif

// *** core/spp_pkg.sv ***
package spp_pkg;
    typedef enum logic [1:0] {
        SPP_LVL_LOW  = 2'b00,
        SPP_LVL_MID  = 2'b01,
        SPP_LVL_HIGH = 2'b10
    } spp_level_t;

    typedef enum logic [2:0] {
        SPP_ST_INIT    = 3'b000,
        SPP_ST_MODE    = 3'b001,
        SPP_ST_REG     = 3'b010,
        SPP_ST_BITS    = 3'b011,
        SPP_ST_LOCKED  = 3'b100
    } spp_state_t;

    typedef struct packed {
        logic mid_prog_pulse;
        logic high_prog_pulse;
    } spp_pulse_t;
endpackage

// *** core/spp_pulse_qual.sv ***
`timescale 1ns/10ps
`include "spp_cfg.svh"
module spp_pulse_qual #(
    parameter int QUAL_CYC = `SPP_QUAL_CYC
) (
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic [1:0]        level_i,
    output spp_pkg::spp_pulse_t    pulse_o,
    output logic                   high_long_o
);
    localparam int CW = 16;
    localparam logic [CW-1:0] QUAL = CW'(QUAL_CYC);
    localparam logic [CW-1:0] BLOW = CW'(`SPP_BLOW_CYC);

    logic [1:0]    last_level;
    logic [CW-1:0] stable_cnt;
    logic [1:0]    peak;
    wire           changed = (level_i != last_level);
    wire           qualified = (stable_cnt >= QUAL);
    wire           falling = changed && (level_i == 2'b00);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            last_level  <= 2'b00;
            stable_cnt  <= '0;
            peak        <= 2'b00;
            pulse_o     <= '0;
            high_long_o <= 1'b0;
        end else begin
            last_level <= level_i;
            stable_cnt <= changed ? '0 : (stable_cnt == '1 ? stable_cnt : stable_cnt + 1'b1);
            // short glitches never latch a peak
            if (qualified && last_level != 2'b00 && last_level > peak) begin
                peak <= last_level;
            end
            high_long_o <= (last_level == 2'b10) && (stable_cnt >= BLOW);
            // pulse counted only on return to low
            pulse_o.mid_prog_pulse  <= falling && (peak == 2'b01);
            pulse_o.high_prog_pulse <= falling && (peak == 2'b10);
            if (falling) begin
                peak <= 2'b00;
            end
        end
    end
endmodule

// *** core/spp_prog_fsm.sv ***
`timescale 1ns/10ps
`include "spp_cfg.svh"
module spp_prog_fsm #(
    parameter int CODE_W   = 6,
    parameter int NUM_REGS = 5,
    parameter int QUAL_CYC = `SPP_QUAL_CYC
) (
    input  wire logic                         clk_i,
    input  wire logic                         sys_rst_i,
    input  wire logic                         supply_ok_i,
    input  wire logic                         lvl_mid_i,
    input  wire logic                         lvl_high_i,
    input  wire logic [NUM_REGS*CODE_W-1:0]   fuse_i,
    output logic      [NUM_REGS*CODE_W-1:0]   fuse_o,
    output logic      [NUM_REGS*CODE_W-1:0]   param_o,
    output logic                              locked_o,
    output logic                              try_mode_o,
    output logic                              blow_mode_o,
    output logic      [3:0]                   sel_key_o,
    output logic      [2:0]                   state_o
);
    // the supply-cycle reset is sys_rst_i; fuse_i is the non-volatile image
    localparam logic [CODE_W-1:0] MAXC = '1;

    spp_pkg::spp_pulse_t  pulse;
    logic                 high_long;
    spp_pkg::spp_state_t  state;
    logic [3:0]           key_cnt;
    logic [3:0]           key;
    logic [CODE_W-1:0]    code;
    logic                 try_mode;
    logic                 blow_mode;
    logic                 blown_done;
    logic [NUM_REGS*CODE_W-1:0] temp;
    logic                 drop_q;

    // comparator outputs; gap while supply not ok is a drop
    wire [1:0] level = !supply_ok_i ? 2'b00 :
                       lvl_high_i   ? 2'b10 :
                       lvl_mid_i    ? 2'b01 : 2'b00;

    spp_pulse_qual #(.QUAL_CYC(QUAL_CYC)) u_qual (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .level_i     (level),
        .pulse_o     (pulse),
        .high_long_o (high_long)
    );

    wire is_locked   = fuse_i[(NUM_REGS-1)*CODE_W];
    wire mid_p       = pulse.mid_prog_pulse;
    wire high_p      = pulse.high_prog_pulse;
    // the drop itself looks like a fall; drop_q covers the strobe it makes
    wire supply_drop = !supply_ok_i || drop_q;
    wire key_ok      = (key_cnt != 4'h0) && (key_cnt <= 4'(NUM_REGS));
    wire [3:0] reg_i = key - 4'h1;
    // code value n drives bit pattern n; blow sets the addressed bits
    wire do_blow     = blow_mode && (state == spp_pkg::SPP_ST_BITS) && high_long
                       && !blown_done && (code != '0);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state      <= spp_pkg::SPP_ST_INIT;
            key_cnt    <= 4'h0;
            key        <= 4'h0;
            code       <= '0;
            try_mode   <= 1'b0;
            blow_mode  <= 1'b0;
            blown_done <= 1'b0;
            temp       <= '0;
        end else if (is_locked) begin
            state <= spp_pkg::SPP_ST_LOCKED;
        end else if (supply_drop) begin
            // partial sequence discarded; temporary values wait for a full cycle
            state     <= spp_pkg::SPP_ST_INIT;
            key_cnt   <= 4'h0;
            try_mode  <= 1'b0;
            blow_mode <= 1'b0;
        end else begin
            if (do_blow) begin
                blown_done <= 1'b1; // one blow per supply cycle
            end
            unique case (state)
                spp_pkg::SPP_ST_INIT: begin
                    if (high_p) begin
                        state   <= spp_pkg::SPP_ST_MODE;
                        key_cnt <= 4'h0;
                    end
                end
                spp_pkg::SPP_ST_MODE: begin
                    if (mid_p) begin
                        key_cnt <= key_cnt + 4'h1;
                    end else if (high_p) begin
                        key_cnt <= 4'h0;
                        if (key_cnt == `SPP_KEY_TRY) begin
                            try_mode <= 1'b1;
                            state    <= spp_pkg::SPP_ST_REG;
                        end else if (key_cnt == `SPP_KEY_BLOW) begin
                            blow_mode <= 1'b1;
                            state     <= spp_pkg::SPP_ST_REG;
                        end else begin
                            state <= spp_pkg::SPP_ST_MODE;
                        end
                    end
                end
                spp_pkg::SPP_ST_REG: begin
                    if (mid_p) begin
                        key_cnt <= key_cnt + 4'h1;
                    end else if (high_p) begin
                        key_cnt <= 4'h0;
                        if (key_ok) begin
                            key   <= key_cnt;
                            code  <= '0;
                            state <= spp_pkg::SPP_ST_BITS;
                        end
                    end
                end
                spp_pkg::SPP_ST_BITS: begin
                    if (mid_p && code != MAXC) begin
                        code <= code + 1'b1;
                        if (try_mode || !blown_done) begin
                            temp[reg_i*CODE_W +: CODE_W] <= code + 1'b1;
                        end
                    end else if (high_p && try_mode) begin
                        state <= spp_pkg::SPP_ST_REG;
                    end
                end
                spp_pkg::SPP_ST_LOCKED: begin
                    state <= spp_pkg::SPP_ST_LOCKED;
                end
                default: begin
                    state <= spp_pkg::SPP_ST_INIT;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            drop_q <= 1'b0;
        end else begin
            drop_q <= !supply_ok_i;
        end
    end

    // blow mode: one register in the selection, no return for another
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fuse_o <= '0;
        end else begin
            fuse_o <= fuse_i | fuse_o;
            if (do_blow) begin
                fuse_o[reg_i*CODE_W +: CODE_W] <= fuse_i[reg_i*CODE_W +: CODE_W]
                    | fuse_o[reg_i*CODE_W +: CODE_W] | code;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            param_o     <= '0;
            locked_o    <= 1'b0;
            try_mode_o  <= 1'b0;
            blow_mode_o <= 1'b0;
            sel_key_o   <= 4'h0;
            state_o     <= 3'b000;
        end else begin
            param_o     <= temp | fuse_i | fuse_o;
            locked_o    <= is_locked;
            try_mode_o  <= try_mode;
            blow_mode_o <= blow_mode;
            sel_key_o   <= key;
            state_o     <= state;
        end
    end
endmodule

// *** bench/spp_prog_fsm_properties.sv ***
`timescale 1ns/10ps
module spp_prog_fsm_properties #(
    parameter int CODE_W   = 6,
    parameter int NUM_REGS = 5,
    parameter int QUAL_CYC = 100
) (
    input wire logic                       clk_i,
    input wire logic                       sys_rst_i,
    input wire logic                       supply_ok_i,
    input wire logic                       lvl_mid_i,
    input wire logic                       lvl_high_i,
    input wire logic [NUM_REGS*CODE_W-1:0] fuse_i,
    input wire logic [NUM_REGS*CODE_W-1:0] fuse_o,
    input wire logic [NUM_REGS*CODE_W-1:0] param_o,
    input wire logic                       locked_o,
    input wire logic                       try_mode_o,
    input wire logic                       blow_mode_o,
    input wire logic [3:0]                 sel_key_o,
    input wire logic [2:0]                 state_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_one_mode; !(try_mode_o && blow_mode_o); endproperty
    a_one_mode: assert property (p_one_mode) else $error("two modes");
    property p_try_rise; $rose(try_mode_o) |-> state_o == 3'h2 && !locked_o; endproperty
    a_try_rise: assert property (p_try_rise) else $error("try entry");
    property p_blow_rise; $rose(blow_mode_o) |-> state_o == 3'h2 && !locked_o; endproperty
    a_blow_rise: assert property (p_blow_rise) else $error("blow entry");
    property p_fuse_keep; ($past(fuse_o) & ~fuse_o) == '0; endproperty
    a_fuse_keep: assert property (p_fuse_keep) else $error("fuse cleared");
    property p_blow_only;
        $changed(fuse_o) && (fuse_o & ~fuse_i) != '0 |-> $past(blow_mode_o) && !$past(locked_o);
    endproperty
    a_blow_only: assert property (p_blow_only) else $error("fuse outside blow");
    property p_at_low; $changed(state_o) |-> !(lvl_mid_i || lvl_high_i) || blow_mode_o; endproperty
    a_at_low: assert property (p_at_low) else $error("step while raised");
    // three quiet cycles give the fuse image time to reach the parameter
    property p_quiet; (state_o != 3'h3 && $stable(fuse_i))[*3] |=> $stable(param_o); endproperty
    a_quiet: assert property (p_quiet) else $error("parameter moved");
    property p_drop;
        !supply_ok_i && !locked_o && $stable(fuse_i) |-> ##2 state_o == 3'h0;
    endproperty
    a_drop: assert property (p_drop) else $error("sequence kept");
    property p_key; sel_key_o <= 4'h5; endproperty
    a_key: assert property (p_key) else $error("key range");
    c_try: cover property ($rose(try_mode_o));
    c_blow: cover property ($rose(blow_mode_o));
    c_lock: cover property ($rose(locked_o));
endmodule
bind spp_prog_fsm spp_prog_fsm_properties #(
    .CODE_W(CODE_W), .NUM_REGS(NUM_REGS), .QUAL_CYC(QUAL_CYC)
) spp_prog_fsm_properties_inst (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .supply_ok_i (supply_ok_i),
    .lvl_mid_i   (lvl_mid_i),
    .lvl_high_i  (lvl_high_i),
    .fuse_i      (fuse_i),
    .fuse_o      (fuse_o),
    .param_o     (param_o),
    .locked_o    (locked_o),
    .try_mode_o  (try_mode_o),
    .blow_mode_o (blow_mode_o),
    .sel_key_o   (sel_key_o),
    .state_o     (state_o)
);

// *** bench/spp_programmer.sv ***
`timescale 1ns/10ps
module spp_programmer (
    input  wire logic clk_i,
    output logic      supply_ok_o,
    output logic      lvl_mid_o,
    output logic      lvl_high_o
);
    localparam int T = 420; // 42 us, a little over the least
    initial begin
        supply_ok_o = 1'b1;
        lvl_mid_o = 1'b0;
        lvl_high_o = 1'b0;
    end
    task automatic pulse(input logic high, input int cyc);
        @(posedge clk_i);
        lvl_high_o <= high;
        lvl_mid_o <= !high;
        repeat (cyc) @(posedge clk_i);
        lvl_high_o <= 1'b0;
        lvl_mid_o <= 1'b0;
        repeat (T) @(posedge clk_i);
    endtask
    task automatic drop(input int cyc);
        @(posedge clk_i);
        supply_ok_o <= 1'b0;
        repeat (cyc) @(posedge clk_i);
        supply_ok_o <= 1'b1;
        repeat (T) @(posedge clk_i);
    endtask
    task automatic mids(input int n);
        repeat (n) pulse(1'b0, T);
    endtask
    task automatic select(input int key);
        pulse(1'b1, T);
        mids(key);
        pulse(1'b1, T);
    endtask
endmodule

// *** bench/spp_prog_fsm_test.sv ***
`timescale 1ns/10ps
module spp_prog_fsm_test;
    logic        clk_i;
    logic        sys_rst_i;
    logic        ok;
    logic        mid;
    logic        high;
    logic [29:0] fuse_img;
    logic [29:0] fuse_o;
    logic [29:0] param_o;
    logic        locked_o;
    logic        try_mode_o;
    logic        blow_mode_o;
    logic [3:0]  sel_key_o;
    logic [2:0]  state_o;
    int          fails;
    int          num_checks;
    spp_prog_fsm #(.CODE_W(6), .NUM_REGS(5), .QUAL_CYC(100)) spp_prog_fsm_inst (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .supply_ok_i (ok),
        .lvl_mid_i   (mid),
        .lvl_high_i  (high),
        .fuse_i      (fuse_img),
        .fuse_o      (fuse_o),
        .param_o     (param_o),
        .locked_o    (locked_o),
        .try_mode_o  (try_mode_o),
        .blow_mode_o (blow_mode_o),
        .sel_key_o   (sel_key_o),
        .state_o     (state_o)
    );
    spp_programmer spp_programmer_inst (
        .clk_i       (clk_i),
        .supply_ok_o (ok),
        .lvl_mid_o   (mid),
        .lvl_high_o  (high)
    );
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // fuses keep their state across supply cycling
    always @(posedge clk_i) fuse_img <= fuse_img | fuse_o;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cycle_supply();
        sys_rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clk_i);
        fails++;
        $display("ERROR watchdog expected end seen hang");
        stop_test();
    end
    initial begin
        sys_rst_i = 1'b1;
        fuse_img = '0;
        fails = 0;
        num_checks = 0;
        cycle_supply();
        check("state", state_o, 3'h0);
        spp_programmer_inst.pulse(1'b0, 50);
        check("state", state_o, 3'h0);
        spp_programmer_inst.pulse(1'b1, 420);
        spp_programmer_inst.mids(1);
        check("mode", state_o, 3'h1);
        spp_programmer_inst.drop(50);
        check("dropped", state_o, 3'h0);
        spp_programmer_inst.select(2);
        check("try", try_mode_o, 1'h1);
        spp_programmer_inst.select(1);
        spp_programmer_inst.mids(3);
        check("key", sel_key_o, 4'h1);
        check("state", state_o, 3'h3);
        check("code", param_o, 30'h0000_0003);
        spp_programmer_inst.pulse(1'b1, 420);
        spp_programmer_inst.select(3);
        spp_programmer_inst.mids(2);
        check("two", param_o, 30'h0000_2003);
        spp_programmer_inst.pulse(1'b1, 420);
        spp_programmer_inst.select(4);
        cycle_supply();
        check("cleared", param_o, 30'h0000_0000);
        $display("try test done");
        spp_programmer_inst.select(1);
        check("blow", blow_mode_o, 1'h1);
        spp_programmer_inst.select(2);
        spp_programmer_inst.mids(4);
        check("addr", param_o, 30'h0000_0100);
        check("unblown", fuse_o, 30'h0000_0000);
        spp_programmer_inst.pulse(1'b1, 420);
        check("blown", fuse_o, 30'h0000_0100);
        cycle_supply();
        check("kept", param_o, 30'h0000_0100);
        $display("blow test done");
        spp_programmer_inst.select(1);
        spp_programmer_inst.select(5);
        spp_programmer_inst.mids(1);
        spp_programmer_inst.pulse(1'b1, 420);
        cycle_supply();
        check("locked", locked_o, 1'h1);
        spp_programmer_inst.select(2);
        check("refused", try_mode_o, 1'h0);
        check("final", param_o, 30'h0100_0100);
        $display("lock test done");
        stop_test();
    end
endmodule
